// ===== bsc_latch.sv
/*
  Boot strap configuration latch: captures strap pins after chip enable rises,
  merges them with sticky fuse bits and presents boot mode, memory supply,
  debug route and boot print selection as registered outputs.
  Assumes pins are asynchronous, fuse and software bits come from mclk logic.
*/
// Function
// - boot parameters come from straps and fuses on every reset, no processor
// - chip active only while chip enable is high; low holds reset
// - each strap has its own latch holding its value until power down
// - latched straps change only on a new reset or power cycle
// - after the sampling window the strap pins are released as GPIO
// - undriven straps read pull defaults: A is 1, supply and B are 0
// - latched strap A at 1 selects flash boot regardless of B
// - A and B both 0 select joint download over serial port or USB
// - flash boot fetches the program from serial flash and runs it
// - override fuse 0: supply strap 0 gives 3.3 V rail, 1 gives 1.8 V
// - override fuse 1: level fuse 0 gives 1.8 V, 1 gives 3.3 V
// - fuses read 0 unprogrammed; once 1 they stay 1
// - no disable fuses and strap-enable fuse 0: debug goes to USB
// - strap-enable fuse 1: debug strap 1 picks USB, 0 picks pins
// - pin disable selects USB, USB disable selects pins, both disable debug
// - boot messages go to serial port and USB, each separately disabled
// - chip select 0 is flash, 1 is RAM; eight-line mode adds lanes
`timescale 1ns/1ps
module bsc_latch
  import bsc_pkg::*;
#(
  parameter int unsigned RST_CYCLES = bsc_pkg::BSC_RST_CYCLES,
  parameter int unsigned HOLD_CYCLES = bsc_pkg::BSC_HOLD_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic chip_enable_pin,
  input wire logic boot_strap_a,
  input wire logic boot_strap_a_driven,
  input wire logic boot_strap_b,
  input wire logic boot_strap_b_driven,
  input wire logic supply_strap,
  input wire logic supply_strap_driven,
  input wire logic debug_source_strap,
  input wire logic supply_override_fuse,
  input wire logic supply_level_fuse,
  input wire logic pin_debug_disable_fuse,
  input wire logic usb_debug_disable_fuse,
  input wire logic debug_strap_enable_fuse,
  input wire logic uart_print_disable_fuse,
  input wire logic usb_print_disable_fuse,
  input wire logic uart_print_disable_reg,
  input wire logic usb_print_disable_reg,
  input wire logic octal_mode,
  output logic chip_active,
  output logic strap_window,
  output logic straps_released,
  output logic config_valid,
  output logic short_reset_seen,
  output logic latched_boot_strap_a,
  output logic latched_boot_strap_b,
  output logic latched_supply_strap,
  output logic latched_debug_source_strap,
  output bsc_pkg::bsc_boot_mode_t boot_mode,
  output logic boot_mode_reserved,
  output logic boot_from_flash,
  output logic download_mode,
  output bsc_pkg::bsc_supply_t memory_supply,
  output bsc_pkg::bsc_debug_route_t debug_route,
  output logic debug_pin_enable,
  output logic debug_usb_enable,
  output logic rom_print_uart,
  output logic rom_print_usb,
  output logic flash_chip_select,
  output logic ram_chip_select,
  output logic [bsc_pkg::BSC_OCTAL_HI_W-1:0] octal_data_hi_en,
  output logic octal_strobe_en
);

  import bsc_pkg::*;

  // strap level with pull default when undriven
  function automatic logic strap_level(input logic driven, input logic lvl, input logic pull);
    strap_level = driven ? lvl : pull;
  endfunction : strap_level

  function automatic bsc_boot_mode_t decode_boot(input logic a, input logic b);
    if (a) begin
      decode_boot = BSC_BOOT_FLASH;
    end else if (!b) begin
      decode_boot = BSC_BOOT_DOWNLOAD;
    end else begin
      decode_boot = BSC_BOOT_RESERVED;
    end
  endfunction : decode_boot

  function automatic bsc_supply_t decode_supply(input logic force_f, input logic strap,
                                                input logic level_f);
    if (!force_f) begin
      decode_supply = strap ? BSC_SUP_1V8_REG : BSC_SUP_3V3_RAIL;
    end else begin
      decode_supply = level_f ? BSC_SUP_3V3_RAIL : BSC_SUP_1V8_REG;
    end
  endfunction : decode_supply

  function automatic bsc_debug_route_t decode_debug(input logic pin_dis, input logic usb_dis,
                                                    input logic sel_en, input logic strap);
    if (pin_dis && usb_dis) begin
      decode_debug = BSC_DBG_OFF;
    end else if (pin_dis) begin
      decode_debug = BSC_DBG_USB;
    end else if (usb_dis) begin
      decode_debug = BSC_DBG_PINS;
    end else if (!sel_en) begin
      decode_debug = BSC_DBG_USB;
    end else begin
      decode_debug = strap ? BSC_DBG_USB : BSC_DBG_PINS;
    end
  endfunction : decode_debug

  logic [BSC_SYNC_W-1:0] pin_async;
  logic [BSC_SYNC_W-1:0] pin_sync;
  logic enable_s;
  bsc_state_t state_q;
  bsc_state_t state_d;
  logic [BSC_CNT_W-1:0] low_cnt_q;
  logic [BSC_CNT_W-1:0] hold_cnt_q;
  logic low_long_enough;
  logic hold_done;
  logic capture;
  logic fuse_sup_force_q;
  logic fuse_sup_level_q;
  logic fuse_pin_dis_q;
  logic fuse_usb_dis_q;
  logic fuse_sel_en_q;
  logic fuse_uart_pr_q;
  logic fuse_usb_pr_q;
  logic a_eff;
  logic b_eff;
  logic sup_eff;
  bsc_boot_mode_t boot_d;
  bsc_debug_route_t dbg_d;

  assign pin_async = {debug_source_strap, supply_strap_driven, supply_strap,
                      boot_strap_b_driven, boot_strap_b, boot_strap_a_driven,
                      boot_strap_a, chip_enable_pin};

  bsc_sync #(
    .WIDTH(BSC_SYNC_W)
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .async_in(pin_async),
    .sync_out(pin_sync)
  );

  assign enable_s = pin_sync[BSC_SYN_EN];
  assign a_eff = strap_level(pin_sync[BSC_SYN_A_DRV], pin_sync[BSC_SYN_A], BSC_PULL_A);
  assign b_eff = strap_level(pin_sync[BSC_SYN_B_DRV], pin_sync[BSC_SYN_B], BSC_PULL_B);
  assign sup_eff = strap_level(pin_sync[BSC_SYN_SUP_DRV], pin_sync[BSC_SYN_SUP],
                               BSC_PULL_SUP);

  assign low_long_enough = (low_cnt_q >= BSC_CNT_W'(RST_CYCLES));
  assign hold_done = (hold_cnt_q == BSC_CNT_W'(HOLD_CYCLES - 1));
  assign capture = (state_q == BSC_ST_HOLD) && enable_s && hold_done;

  // enable sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      BSC_ST_OFF: begin
        if (enable_s) begin
          if (low_long_enough || !config_valid) begin
            state_d = BSC_ST_HOLD;
          end else begin
            state_d = BSC_ST_RUN;
          end
        end
      end
      BSC_ST_HOLD: begin
        if (!enable_s) begin
          state_d = BSC_ST_OFF;
        end else if (hold_done) begin
          state_d = BSC_ST_RUN;
        end
      end
      BSC_ST_RUN: begin
        if (!enable_s) begin
          state_d = BSC_ST_OFF;
        end
      end
      default: begin
        state_d = BSC_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= BSC_ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // time chip enable has been low, saturating
  always_ff @(posedge mclk) begin
    if (reset) begin
      low_cnt_q <= '0;
    end else if (state_q != BSC_ST_OFF) begin
      low_cnt_q <= '0;
    end else if (!low_long_enough) begin
      low_cnt_q <= low_cnt_q + 1'h1;
    end
  end

  // strap hold window
  always_ff @(posedge mclk) begin
    if (reset) begin
      hold_cnt_q <= '0;
    end else if (state_q != BSC_ST_HOLD) begin
      hold_cnt_q <= '0;
    end else if (!hold_done) begin
      hold_cnt_q <= hold_cnt_q + 1'h1;
    end
  end

  // glitch on enable too short to reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      short_reset_seen <= 1'h0;
    end else if (state_q == BSC_ST_OFF && enable_s) begin
      short_reset_seen <= !low_long_enough && config_valid;
    end
  end

  // sticky fuse shadows
  always_ff @(posedge mclk) begin
    if (reset) begin
      fuse_sup_force_q <= BSC_FUSE_CLEAR;
      fuse_sup_level_q <= BSC_FUSE_CLEAR;
      fuse_pin_dis_q <= BSC_FUSE_CLEAR;
      fuse_usb_dis_q <= BSC_FUSE_CLEAR;
      fuse_sel_en_q <= BSC_FUSE_CLEAR;
      fuse_uart_pr_q <= BSC_FUSE_CLEAR;
      fuse_usb_pr_q <= BSC_FUSE_CLEAR;
    end else begin
      fuse_sup_force_q <= fuse_sup_force_q | supply_override_fuse;
      fuse_sup_level_q <= fuse_sup_level_q | supply_level_fuse;
      fuse_pin_dis_q <= fuse_pin_dis_q | pin_debug_disable_fuse;
      fuse_usb_dis_q <= fuse_usb_dis_q | usb_debug_disable_fuse;
      fuse_sel_en_q <= fuse_sel_en_q | debug_strap_enable_fuse;
      fuse_uart_pr_q <= fuse_uart_pr_q | uart_print_disable_fuse;
      fuse_usb_pr_q <= fuse_usb_pr_q | usb_print_disable_fuse;
    end
  end

  // strap latches, written only at capture
  always_ff @(posedge mclk) begin
    if (reset) begin
      latched_boot_strap_a <= BSC_PULL_A;
      latched_boot_strap_b <= BSC_PULL_B;
      latched_supply_strap <= BSC_PULL_SUP;
      latched_debug_source_strap <= 1'h0;
    end else if (capture) begin
      latched_boot_strap_a <= a_eff;
      latched_boot_strap_b <= b_eff;
      latched_supply_strap <= sup_eff;
      latched_debug_source_strap <= pin_sync[BSC_SYN_DBG];
    end
  end

  assign boot_d = decode_boot(a_eff, b_eff);
  assign dbg_d = decode_debug(fuse_pin_dis_q, fuse_usb_dis_q, fuse_sel_en_q,
                              pin_sync[BSC_SYN_DBG]);

  // derived settings, frozen at capture
  always_ff @(posedge mclk) begin
    if (reset) begin
      boot_mode <= BSC_BOOT_FLASH;
      boot_mode_reserved <= 1'h0;
      memory_supply <= BSC_SUP_3V3_RAIL;
      debug_route <= BSC_DBG_USB;
    end else if (capture) begin
      boot_mode <= boot_d;
      boot_mode_reserved <= (boot_d == BSC_BOOT_RESERVED);
      memory_supply <= decode_supply(fuse_sup_force_q, sup_eff, fuse_sup_level_q);
      debug_route <= dbg_d;
    end
  end

  // configuration valid once first capture done
  always_ff @(posedge mclk) begin
    if (reset) begin
      config_valid <= 1'h0;
    end else if (capture) begin
      config_valid <= 1'h1;
    end
  end

  // chip activity and pin ownership
  always_ff @(posedge mclk) begin
    if (reset) begin
      chip_active <= 1'h0;
      strap_window <= 1'h0;
      straps_released <= 1'h0;
    end else begin
      chip_active <= (state_d == BSC_ST_RUN);
      strap_window <= (state_d == BSC_ST_HOLD);
      straps_released <= (state_d == BSC_ST_RUN);
    end
  end

  // boot actions gated by activity
  always_ff @(posedge mclk) begin
    if (reset) begin
      boot_from_flash <= 1'h0;
      download_mode <= 1'h0;
      debug_pin_enable <= 1'h0;
      debug_usb_enable <= 1'h0;
    end else begin
      boot_from_flash <= chip_active && (boot_mode == BSC_BOOT_FLASH);
      download_mode <= chip_active && (boot_mode == BSC_BOOT_DOWNLOAD);
      debug_pin_enable <= chip_active && (debug_route == BSC_DBG_PINS);
      debug_usb_enable <= chip_active && (debug_route == BSC_DBG_USB);
    end
  end

  // boot message routing
  always_ff @(posedge mclk) begin
    if (reset) begin
      rom_print_uart <= 1'h0;
      rom_print_usb <= 1'h0;
    end else begin
      rom_print_uart <= chip_active && !fuse_uart_pr_q && !uart_print_disable_reg;
      rom_print_usb <= chip_active && !fuse_usb_pr_q && !usb_print_disable_reg;
    end
  end

  // memory interface lanes
  always_ff @(posedge mclk) begin
    if (reset) begin
      flash_chip_select <= BSC_FLASH_CS;
      ram_chip_select <= BSC_RAM_CS;
      octal_data_hi_en <= BSC_OCTAL_HI_OFF;
      octal_strobe_en <= 1'h0;
    end else begin
      flash_chip_select <= BSC_FLASH_CS;
      ram_chip_select <= BSC_RAM_CS;
      octal_data_hi_en <= (chip_active && octal_mode) ? BSC_OCTAL_HI_ON : BSC_OCTAL_HI_OFF;
      octal_strobe_en <= chip_active && octal_mode;
    end
  end

endmodule : bsc_latch

// ===== bsc_pkg.sv
/*
  Constants, timing figures and enumerations for the boot strap configuration latch.
  Assumes a single 100 MHz clock domain and a synchronous active-high reset.
*/
package bsc_pkg;

  // clock rate
  localparam int unsigned BSC_CLK_MHZ = 100;

  // least time chip enable stays low to count as a reset, in microseconds
  localparam int unsigned BSC_RST_TIME_US = 50;
  // least strap hold time after chip enable rises, in milliseconds
  localparam int unsigned BSC_HOLD_TIME_MS = 3;

  // derived cycle counts, least times round up
  localparam int unsigned BSC_RST_CYCLES = BSC_RST_TIME_US * BSC_CLK_MHZ;
  localparam int unsigned BSC_HOLD_CYCLES = BSC_HOLD_TIME_MS * 1000 * BSC_CLK_MHZ;

  // width of both timing counters, low time and hold window
  localparam int unsigned BSC_CNT_W = 20;

  // pin synchroniser layout
  localparam int unsigned BSC_SYNC_W = 8;
  localparam int unsigned BSC_SYN_EN = 0;
  localparam int unsigned BSC_SYN_A = 1;
  localparam int unsigned BSC_SYN_A_DRV = 2;
  localparam int unsigned BSC_SYN_B = 3;
  localparam int unsigned BSC_SYN_B_DRV = 4;
  localparam int unsigned BSC_SYN_SUP = 5;
  localparam int unsigned BSC_SYN_SUP_DRV = 6;
  localparam int unsigned BSC_SYN_DBG = 7;

  // internal pull defaults of undriven straps
  localparam logic BSC_PULL_A = 1'h1;
  localparam logic BSC_PULL_B = 1'h0;
  localparam logic BSC_PULL_SUP = 1'h0;

  // unprogrammed fuse value
  localparam logic BSC_FUSE_CLEAR = 1'h0;

  // chip select assignment of in-package memories
  localparam logic BSC_FLASH_CS = 1'h0;
  localparam logic BSC_RAM_CS = 1'h1;

  // eight-line mode extra lanes
  localparam int unsigned BSC_OCTAL_HI_W = 4;
  localparam logic [BSC_OCTAL_HI_W-1:0] BSC_OCTAL_HI_ON = 4'hF;
  localparam logic [BSC_OCTAL_HI_W-1:0] BSC_OCTAL_HI_OFF = 4'h0;

  typedef enum logic [1:0] {
    BSC_BOOT_FLASH,
    BSC_BOOT_DOWNLOAD,
    BSC_BOOT_RESERVED
  } bsc_boot_mode_t;

  typedef enum logic [1:0] {
    BSC_DBG_USB,
    BSC_DBG_PINS,
    BSC_DBG_OFF
  } bsc_debug_route_t;

  typedef enum logic {
    BSC_SUP_3V3_RAIL,
    BSC_SUP_1V8_REG
  } bsc_supply_t;

  typedef enum logic [1:0] {
    BSC_ST_OFF,
    BSC_ST_HOLD,
    BSC_ST_RUN
  } bsc_state_t;

endpackage : bsc_pkg

// ===== bsc_sync.sv
/*
  Two-stage synchroniser for a group of pin levels.
  Assumes the inputs are asynchronous levels and that reset is synchronous to mclk.
*/
`timescale 1ns/1ps
module bsc_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : bsc_sync

// ===== bsc_latch_sva.sv
/* Concurrent checks on the ports of the boot strap latch.
   Assumes one mclk domain with synchronous active-high reset; bound into bsc_latch. */
`timescale 1ns/1ps
module bsc_latch_chk
  import bsc_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = 8
) (
  input logic mclk,
  input logic reset,
  input logic chip_enable_pin,
  input logic uart_print_disable_reg,
  input logic chip_active,
  input logic strap_window,
  input logic config_valid,
  input logic latched_boot_strap_a,
  input logic latched_boot_strap_b,
  input logic latched_supply_strap,
  input logic latched_debug_source_strap,
  input bsc_pkg::bsc_boot_mode_t boot_mode,
  input bsc_pkg::bsc_supply_t memory_supply,
  input logic boot_from_flash,
  input bsc_pkg::bsc_debug_route_t debug_route,
  input logic debug_pin_enable,
  input logic rom_print_uart
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [19:0] win_cnt_q;
  // cycles spent in the sampling window
  always_ff @(posedge mclk) begin
    if (reset || !strap_window) begin
      win_cnt_q <= 20'h0;
    end else begin
      win_cnt_q <= win_cnt_q + 20'h1;
    end
  end
  sequence s_capture;
    $fell(strap_window) ##0 chip_active;
  endsequence
  sequence s_pin_low;
    !chip_enable_pin [*3];
  endsequence
  chk_window_len:
    assert property (s_capture |-> win_cnt_q == HOLD_CYCLES) else $error("window length");
  chk_latch_stable:
    assert property (!$fell(strap_window) |-> $stable({latched_boot_strap_a,
      latched_boot_strap_b, latched_supply_strap, latched_debug_source_strap}))
      else $error("latch moved");
  chk_derived_stable:
    assert property (!$fell(strap_window) |-> $stable({boot_mode, memory_supply, debug_route}))
      else $error("derived moved");
  chk_boot_decode:
    assert property (config_valid |-> boot_mode == (latched_boot_strap_a ? BSC_BOOT_FLASH :
      latched_boot_strap_b ? BSC_BOOT_RESERVED : BSC_BOOT_DOWNLOAD)) else $error("boot decode");
  chk_enable_off:
    assert property (s_pin_low |=> !chip_active) else $error("active while off");
  chk_flash_gate:
    assert property (boot_from_flash == ($past(chip_active) && $past(boot_mode) ==
      BSC_BOOT_FLASH)) else $error("flash gate");
  chk_debug_gate:
    assert property (debug_pin_enable == ($past(chip_active) && $past(debug_route) ==
      BSC_DBG_PINS)) else $error("debug gate");
  chk_print_live:
    assert property (rom_print_uart |-> $past(chip_active) && !$past(uart_print_disable_reg))
      else $error("print gate");
  chk_config_sticky:
    assert property (config_valid |=> config_valid) else $error("config lost");
endmodule : bsc_latch_chk

bind bsc_latch bsc_latch_chk #(.HOLD_CYCLES(HOLD_CYCLES)) u_bsc_latch_chk (.*);

// ===== bsc_host_model.sv
/* Reset circuit and strap drivers facing the boot strap latch.
   Driven by the bench through power_cycle; shares mclk with the design. */
`timescale 1ns/1ps
module bsc_host_model #(
  parameter int unsigned HOLD_CYCLES = 8
) (
  input logic mclk,
  output logic chip_enable_pin,
  output logic boot_strap_a,
  output logic boot_strap_a_driven,
  output logic boot_strap_b,
  output logic boot_strap_b_driven,
  output logic supply_strap,
  output logic supply_strap_driven,
  output logic debug_source_strap
);
  logic hold_q = 1'b0;
  logic [6:0] pins_q = 7'h0;
  assign {debug_source_strap, supply_strap_driven, supply_strap, boot_strap_b_driven,
    boot_strap_b, boot_strap_a_driven, boot_strap_a} = pins_q;
  initial begin
    chip_enable_pin = 1'b0;
  end
  // pins serve as ordinary io once the hold is over
  always @(posedge mclk) begin
    if (!hold_q) begin
      pins_q <= ~pins_q;
    end
  end
  // s is debug, supply drv, supply, b drv, b, a drv, a
  task automatic power_cycle(input int low, input logic [6:0] s);
    @(posedge mclk);
    hold_q <= 1'b1;
    chip_enable_pin <= 1'b0;
    @(posedge mclk);
    // undriven lines show the inverse of the pull debug strap driven
    pins_q <= {s[6], s[5], s[5] ? s[4] : 1'b1, s[3], s[3] ? s[2] : 1'b1, s[1], s[1] & s[0]};
    repeat (low) @(posedge mclk);
    chip_enable_pin <= 1'b1;
    repeat (HOLD_CYCLES + 12) @(posedge mclk);
    hold_q <= 1'b0;
  endtask : power_cycle
endmodule : bsc_host_model

// ===== bsc_latch_tb_top.sv
/* Self-checking bench for bsc_latch against a reference of the strap rules.
   Pins come from bsc_host_model; the checker is bound from bsc_latch_sva.sv. */
`timescale 1ns/1ps
module bsc_latch_tb_top;
  import bsc_pkg::*;
  localparam int unsigned RST = 4;
  localparam int unsigned HOLD = 8;
  logic mclk, reset, chip_enable_pin, boot_strap_a, boot_strap_a_driven, boot_strap_b;
  logic boot_strap_b_driven, supply_strap, supply_strap_driven, debug_source_strap;
  logic supply_override_fuse, supply_level_fuse, pin_debug_disable_fuse;
  logic usb_debug_disable_fuse, debug_strap_enable_fuse, uart_print_disable_fuse;
  logic usb_print_disable_fuse, uart_print_disable_reg, usb_print_disable_reg, octal_mode;
  logic chip_active, strap_window, straps_released, config_valid, short_reset_seen;
  logic latched_boot_strap_a, latched_boot_strap_b, latched_supply_strap;
  logic latched_debug_source_strap, boot_mode_reserved, boot_from_flash, download_mode;
  logic debug_pin_enable, debug_usb_enable, rom_print_uart, rom_print_usb;
  logic flash_chip_select, ram_chip_select, octal_strobe_en;
  logic [3:0] octal_data_hi_en;
  bsc_boot_mode_t boot_mode;
  bsc_supply_t memory_supply;
  bsc_debug_route_t debug_route;
  logic [6:0] fuse_q;
  logic [2:0] ctl_q;
  int num_errors = 0;
  int check_count = 0;
  int ea, eb, es, ed;
  assign {usb_print_disable_fuse, uart_print_disable_fuse, debug_strap_enable_fuse,
    usb_debug_disable_fuse, pin_debug_disable_fuse, supply_level_fuse,
    supply_override_fuse} = fuse_q;
  assign {octal_mode, usb_print_disable_reg, uart_print_disable_reg} = ctl_q;
  bsc_latch #(.RST_CYCLES(RST), .HOLD_CYCLES(HOLD)) u_bsc_latch (.*);
  bsc_host_model #(.HOLD_CYCLES(HOLD)) u_bsc_host_model (.*);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input string nm, input logic [4:0] seen, input logic [4:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // reset, burn fuses, power up with straps, compare every derived output
  task automatic run_case(input int i);
    logic [6:0] s;
    logic [6:0] f;
    logic [2:0] c;
    int em, eu, er;
    s = 7'($urandom);
    f = 7'($urandom);
    c = 3'($urandom);
    if (i < 32) begin
      {s[6], f[4], f[2], s[2], s[0]} = 5'(i);
      s[3] = 1'b1;
      s[1] = 1'b1;
    end
    @(posedge mclk);
    reset <= 1'b1;
    fuse_q <= f;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    fuse_q <= 7'h0;
    u_bsc_host_model.power_cycle(RST + 2, s);
    ctl_q <= c;
    repeat (2) @(posedge mclk);
    #1;
    ea = s[1] ? s[0] : 1;
    eb = s[3] ? s[2] : 0;
    es = s[5] ? s[4] : 0;
    ed = s[6];
    em = ea ? 0 : (eb ? 2 : 1);
    eu = f[0] ? !f[1] : es;
    er = (f[2] && f[3]) ? 2 : f[2] ? 0 : f[3] ? 1 : (f[4] && !ed) ? 1 : 0;
    check("latched_a", latched_boot_strap_a, ea);
    check("latched_b", latched_boot_strap_b, eb);
    check("latched_sup", latched_supply_strap, es);
    check("latched_dbg", latched_debug_source_strap, ed);
    check("boot_mode", boot_mode, em);
    check("reserved", boot_mode_reserved, em == 2);
    check("flash", boot_from_flash, em == 0);
    check("download", download_mode, em == 1);
    check("supply", memory_supply, eu);
    check("debug", debug_route, er);
    check("dbg_pins", debug_pin_enable, er == 1);
    check("dbg_usb", debug_usb_enable, er == 0);
    check("print_uart", rom_print_uart, !f[5] && !c[0]);
    check("print_usb", rom_print_usb, !f[6] && !c[1]);
    check("octal", {octal_strobe_en, octal_data_hi_en}, c[2] ? 5'h1F : 5'h0);
    check("chip_sel", {flash_chip_select, ram_chip_select}, 2'h1);
    check("run", {chip_active, straps_released, config_valid, short_reset_seen},
      4'hE);
    $display("case %0d done", i);
  endtask : run_case
  initial begin
    reset = 1'b1;
    fuse_q = 7'h0;
    ctl_q = 3'h0;
    void'($urandom(70));
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 48; i++) begin
      run_case(i);
    end
    // brief low on enable with new straps keeps the old capture
    u_bsc_host_model.power_cycle(1, {ed == 0, 1'b1, es == 0, 1'b1, eb == 0, 1'b1, ea == 0});
    repeat (2) @(posedge mclk);
    #1;
    check("short_keep", {short_reset_seen, latched_debug_source_strap, latched_supply_strap,
      latched_boot_strap_b, latched_boot_strap_a}, {1'b1, ed[0], es[0], eb[0], ea[0]});
    check("short_run", chip_active, 1'b1);
    $display("short reset done");
    // long low after a valid capture takes the new straps
    u_bsc_host_model.power_cycle(RST + 2, {ed == 0, 1'h1, es == 0, 1'h1, eb == 0, 1'h1, ea == 0});
    repeat (2) @(posedge mclk);
    #1;
    check("long_new", {short_reset_seen, latched_debug_source_strap, latched_supply_strap,
      latched_boot_strap_b, latched_boot_strap_a},
      {1'h0, ed == 0, es == 0, eb == 0, ea == 0});
    $display("long reset done");
    complete_run();
  end
  initial begin
    repeat (10000) @(posedge mclk);
    num_errors++;
    complete_run();
  end
endmodule : bsc_latch_tb_top
